// ---- logic/rspf_pkg.sv ----
// Package for the reset, strap and pin-function block: register map,
// field positions, reset values, operating modes and timing counts.
// Assumes a 125 MHz core clock and 32-bit AHB-Lite register access.
package rspf_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] PORT_E_ASSIGN_OFS = 8'h00;
  localparam logic [7:0] EXT_BUS_CTRL_OFS  = 8'h04;
  localparam logic [7:0] PULLUP_CTRL_OFS   = 8'h08;
  localparam logic [7:0] PORT_S_PULL_OFS   = 8'h0C;
  localparam logic [7:0] AUX_PULL_OFS      = 8'h10;
  localparam logic [7:0] STATUS_OFS        = 8'h14;

  // Field positions in the port-E assignment register.
  localparam int FREE_CYCLE_EN_BIT = 0;
  localparam int RW_PIN_EN_BIT     = 2;
  localparam int LOW_STROBE_EN_BIT = 3;
  localparam int BUS_CLOCK_OUT_DISABLE_BIT  = 4;
  // Field positions in the external bus control register.
  localparam int STRETCH_EN_BIT    = 0;
  localparam int STRETCH_LSB       = 1;
  localparam int INT_VIS_BIT       = 3;
  localparam int TAG_EN_BIT        = 4;
  // Field position in the pull-up control register.
  localparam int PE_PULLUP_EN_BIT  = 4;
  // Port-S register: enables in the low byte, polarities in the next.
  localparam int PS_POL_LSB        = 8;
  // Status register fields.
  localparam int ST_OSC_BIT        = 3;
  localparam int ST_RUN_BIT        = 4;
  localparam int ST_INTRST_BIT     = 5;

  // Reset values.
  localparam logic [1:0] STRETCH_RST   = 2'h3;
  localparam logic       PE_PULLUP_RST = 1'b1;
  localparam logic [7:0] PS_EN_RST     = 8'hFF;
  localparam logic [7:0] PS_POL_RST    = 8'h00;
  localparam logic [4:0] AUX_PULL_RST  = 5'h00;

  // Operating modes as {mode_strap_c, mode_strap_b, mode_strap_a}.
  localparam logic [2:0] MODE_SPECIAL_TEST  = 3'h2;
  localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
  localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;

  // Timing: clock period, internal reset drive time, pin rise allowance.
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int RST_DRIVE_NS   = 512;
  localparam int RST_DRIVE_CYC  = (RST_DRIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RISE_BUS_CLOCK_OUT_CYC  = 32;
  localparam int RISE_CYC       = RISE_BUS_CLOCK_OUT_CYC * 2;

  // Reset sequence states, Gray coded along run, drive, settle.
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_DRIVE  = 2'b01,
    ST_SETTLE = 2'b11
  } rspf_state_t;

  // Straps caught at reset release.
  typedef struct packed {
    logic [2:0] mode;
    logic       osc_sel;
  } rspf_strap_t;

  // One driven pin: output level and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } rspf_pin_t;

endpackage

// ---- logic/rspf_top.sv ----
// Reset pin, strap capture, bus-clock output and pin-function control.
// Assumes one 125 MHz clock, an AHB-Lite master and pins from off chip.
// What this block does
// - On any reset, drive pin low, sequence.
// - Reset pin input plus open-drain failure output.
// - Capture mode straps at reset rising edge.
// - Mode-strap pull-downs only while reset low.
// - Low debug pin at falling clock tags high half.
// - Free-cycle indicator asserts when core bus idle.
// - Sample oscillator select strap at reset release.
// - Clock pin outputs except normal single chip.
// - Bus clock out is half input clock.
// - Bus clock stops in stop mode.
// - Disable, visibility, stretch bits govern clock out.
// - Two-bit stretch for slow memory, default on.
// - Special test mode: strobe and rw enables set.
// - Clearing port-E pull-up enable drops pull-up.
// - Ports A and B carry expanded bus.
// - Normal narrow mode: clock out never stretched.
// - Port S pulls on at reset, per-pin selectable.
// - Ports T,P,Q,U and DAC pulls off.
// - No low-byte strobe until its enable set.
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module rspf_top (
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  // AHB-Lite slave port.
  input  wire logic              hsel_i,
  input  wire logic [7:0]        haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  output logic [31:0]            hrdata_o,
  output logic                   hresp_o,
  // Reset pin, open drain, and internal failure sources.
  input  wire logic              reset_pin_i,
  output logic                   reset_pin_o,
  output logic                   reset_pin_oe_o,
  input  wire logic              watchdog_monitor_fail_i,
  input  wire logic              clock_monitor_fail_i,
  output logic                   core_run_o,
  // Strap pins and debug pin.
  input  wire logic              mode_strap_c_i,
  input  wire logic              mode_strap_b_i,
  input  wire logic              mode_strap_a_i,
  input  wire logic              osc_select_strap_i,
  input  wire logic              debug_pin_i,
  output logic                   strap_pulldown_o,
  output logic                   tag_high_half_o,
  // Core status from the same clock domain.
  input  wire logic              stop_mode_i,
  input  wire logic              cpu_bus_busy_i,
  input  wire logic              ext_access_i,
  // Pin function outputs.
  output logic                   free_cycle_indicator_o,
  output rspf_pkg::rspf_pin_t    bus_clock_out_o,
  output logic                   bus_clock_pullup_o,
  output logic                   rw_pin_oe_o,
  output logic                   low_strobe_oe_o,
  output logic                   pe32_pullup_o,
  output logic                   port_ab_bus_sel_o,
  output logic [7:0]             port_s_pullup_o,
  output logic [7:0]             port_s_pulldown_o,
  output logic [4:0]             aux_pull_enable_o
);
  import rspf_pkg::*;

  logic [1:0]  rst_sync;      // Reset release synchroniser.
  logic        rst_n;         // Internal reset copy.
  logic [1:0]  rpin_sync;     // Reset pin synchroniser.
  logic [1:0]  dbg_sync;      // Debug pin synchroniser.
  rspf_strap_t strap_s1;      // Strap synchroniser first stage.
  rspf_strap_t strap_s2;      // Strap synchroniser second stage.
  rspf_strap_t strap;         // Captured straps.
  rspf_state_t state;         // Reset sequence state.
  rspf_state_t next_state;    // Its next value.
  logic [7:0]  seq_cnt;       // Drive and settle counter.
  logic        int_reset;     // Last reset came from an internal failure.
  logic        capture;       // Straps are caught in this cycle.
  logic        fail;          // Any internal failure.
  logic        expanded;      // Captured mode uses the external bus.
  // Register fields.
  logic        free_cycle_en;
  logic        rw_pin_en;
  logic        low_strobe_enable;
  logic        bus_clock_out_disable;
  logic        bus_clock_stretch_enable;
  logic [1:0]  stretch_amount;
  logic        internal_visibility;
  logic        tag_en;
  logic        port_e_pullup_enable;
  logic [7:0]  port_s_pull_enable;
  logic [7:0]  port_s_pull_polarity;
  logic [4:0]  aux_pull_en;
  // Bus clock generator.
  logic        bus_clock_out;
  logic [1:0]  stretch_cnt;
  logic        bus_clock_out_hold;
  logic        bus_clock_out_oe;
  // AHB-Lite data phase.
  logic        wr_pend;
  logic [7:0]  wr_addr;

  // Reset is released through two flops; assertion stays asynchronous.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pins from off chip pass two flops before any logic reads them.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rpin_sync <= 2'h0;
      dbg_sync  <= 2'h3;
      strap_s1  <= '0;
      strap_s2  <= '0;
    end else begin
      rpin_sync <= {rpin_sync[0], reset_pin_i};
      dbg_sync  <= {dbg_sync[0], debug_pin_i};
      strap_s1  <= {mode_strap_c_i, mode_strap_b_i, mode_strap_a_i, osc_select_strap_i};
      strap_s2  <= strap_s1;
    end
  end

  assign fail = watchdog_monitor_fail_i | clock_monitor_fail_i;
  // The pin is caught high in settle: that is the reset rising edge.
  assign capture = (state == ST_SETTLE) && rpin_sync[1];

  // Reset sequence: drive, release, wait for the pin to rise, then run.
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (fail || !rpin_sync[1]) begin
          next_state = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (seq_cnt == 8'(RST_DRIVE_CYC - 1)) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // An external hold keeps us here; a slow rise is waited out.
        if (capture) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_DRIVE;
      end
    endcase
  end

  // State, counter and reset source; a fresh reset always drives first.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_DRIVE;
      seq_cnt   <= 8'h00;
      int_reset <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        seq_cnt <= 8'h00;
      end else if (seq_cnt != 8'hFF) begin
        seq_cnt <= seq_cnt + 8'h01;
      end
      if (state == ST_RUN && next_state == ST_DRIVE) begin
        int_reset <= fail;
      end
    end
  end

  // Open-drain reset pin: only ever low, enabled while driving.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_o      <= 1'b0;
      reset_pin_oe_o   <= 1'b1;
      core_run_o       <= 1'b0;
      strap_pulldown_o <= 1'b1;
    end else begin
      reset_pin_o      <= 1'b0;
      reset_pin_oe_o   <= (next_state == ST_DRIVE);
      core_run_o       <= (next_state == ST_RUN);
      // Pull-downs follow reset low, so they never load the pins in use.
      strap_pulldown_o <= !rpin_sync[1] || (next_state != ST_RUN);
    end
  end

  // Straps are caught once per reset and then left alone.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      strap <= '0;
    end else if (capture) begin
      strap <= strap_s2;
    end
  end

  // Special test mode is counted with the expanded modes.
  assign expanded = strap.mode[0] || (strap.mode == MODE_SPECIAL_TEST);

  // Port-E assignment and bus control registers: mode-dependent reset
  // values are loaded at capture, since the mode is unknown before.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      free_cycle_en            <= 1'b0;
      rw_pin_en                <= 1'b0;
      low_strobe_enable        <= 1'b0;
      bus_clock_out_disable    <= 1'b1;
      bus_clock_stretch_enable <= 1'b0;
      stretch_amount           <= STRETCH_RST;
      internal_visibility      <= 1'b0;
      tag_en                   <= 1'b0;
    end else if (capture) begin
      free_cycle_en            <= 1'b0;
      rw_pin_en                <= (strap_s2.mode == MODE_SPECIAL_TEST);
      low_strobe_enable        <= (strap_s2.mode == MODE_SPECIAL_TEST);
      bus_clock_out_disable    <= (strap_s2.mode == MODE_NORMAL_SINGLE);
      bus_clock_stretch_enable <= strap_s2.mode[0] ||
                                  (strap_s2.mode == MODE_SPECIAL_TEST);
      stretch_amount           <= STRETCH_RST;
      internal_visibility      <= 1'b0;
      tag_en                   <= 1'b0;
    end else if (wr_pend && wr_addr == PORT_E_ASSIGN_OFS) begin
      free_cycle_en            <= hwdata_i[FREE_CYCLE_EN_BIT];
      rw_pin_en                <= hwdata_i[RW_PIN_EN_BIT];
      low_strobe_enable        <= hwdata_i[LOW_STROBE_EN_BIT];
      bus_clock_out_disable    <= hwdata_i[BUS_CLOCK_OUT_DISABLE_BIT];
    end else if (wr_pend && wr_addr == EXT_BUS_CTRL_OFS) begin
      bus_clock_stretch_enable <= hwdata_i[STRETCH_EN_BIT];
      stretch_amount           <= hwdata_i[STRETCH_LSB +: 2];
      internal_visibility      <= hwdata_i[INT_VIS_BIT];
      tag_en                   <= hwdata_i[TAG_EN_BIT];
    end
  end

  // Pull control registers; port S and the port-E pull-up start on, the rest off.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      port_e_pullup_enable <= PE_PULLUP_RST;
      port_s_pull_enable   <= PS_EN_RST;
      port_s_pull_polarity <= PS_POL_RST;
      aux_pull_en          <= AUX_PULL_RST;
    end else if (wr_pend) begin
      case (wr_addr)
        PULLUP_CTRL_OFS: begin
          port_e_pullup_enable <= hwdata_i[PE_PULLUP_EN_BIT];
        end
        PORT_S_PULL_OFS: begin
          port_s_pull_enable   <= hwdata_i[7:0];
          port_s_pull_polarity <= hwdata_i[PS_POL_LSB +: 8];
        end
        AUX_PULL_OFS: begin
          aux_pull_en <= hwdata_i[4:0];
        end
        default: begin
          aux_pull_en <= aux_pull_en;
        end
      endcase
    end
  end

  // Stretch holds the high phase only for external accesses, never in
  // normal narrow mode where the clock must keep a constant rate.
  assign bus_clock_out_hold = stop_mode_i || (bus_clock_out && stretch_cnt != 2'h0);

  // Bus clock: toggles every core edge, giving half the input rate.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_clock_out        <= 1'b0;
      stretch_cnt <= 2'h0;
    end else if (!bus_clock_out_hold) begin
      bus_clock_out <= !bus_clock_out;
      if (!bus_clock_out && ext_access_i && bus_clock_stretch_enable &&
          strap.mode != MODE_NORMAL_NARROW) begin
        stretch_cnt <= stretch_amount;
      end else begin
        stretch_cnt <= 2'h0;
      end
    end else if (!stop_mode_i) begin
      stretch_cnt <= stretch_cnt - 2'h1;
    end
  end

  // The clock pin drives unless disabled; visibility keeps it on outside normal single chip.
  assign bus_clock_out_oe = (!bus_clock_out_disable || internal_visibility) &&
                   (strap.mode != MODE_NORMAL_SINGLE);

  // Pin-function outputs, all registered.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_clock_out_o        <= '0;
      bus_clock_pullup_o     <= 1'b1;
      rw_pin_oe_o            <= 1'b0;
      low_strobe_oe_o        <= 1'b0;
      pe32_pullup_o          <= 1'b1;
      port_ab_bus_sel_o      <= 1'b0;
      free_cycle_indicator_o <= 1'b0;
      tag_high_half_o        <= 1'b0;
    end else begin
      bus_clock_out_o.o      <= bus_clock_out_hold ? bus_clock_out : !bus_clock_out;
      bus_clock_out_o.oe     <= bus_clock_out_oe;
      bus_clock_pullup_o     <= !bus_clock_out_oe && port_e_pullup_enable;
      rw_pin_oe_o            <= rw_pin_en;
      low_strobe_oe_o        <= low_strobe_enable;
      pe32_pullup_o          <= !(rw_pin_en && low_strobe_enable) &&
                                port_e_pullup_enable;
      port_ab_bus_sel_o      <= expanded && core_run_o;
      free_cycle_indicator_o <= expanded && free_cycle_en && !cpu_bus_busy_i;
      // Falling edge of the bus clock: high now, low next.
      tag_high_half_o        <= expanded && tag_en && bus_clock_out && !bus_clock_out_hold &&
                                !dbg_sync[1];
    end
  end

  // Port-S pull per pin: polarity zero pulls up, one pulls down.
  for (genvar i = 0; i < 8; i++) begin : g_port_s
    always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
        port_s_pullup_o[i]   <= 1'b1;
        port_s_pulldown_o[i] <= 1'b0;
      end else begin
        port_s_pullup_o[i]   <= port_s_pull_enable[i] && !port_s_pull_polarity[i];
        port_s_pulldown_o[i] <= port_s_pull_enable[i] && port_s_pull_polarity[i];
      end
    end
  end

  // Other ports' pull enables go straight from their register.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      aux_pull_enable_o <= AUX_PULL_RST;
    end else begin
      aux_pull_enable_o <= aux_pull_en;
    end
  end

  // AHB-Lite: zero wait states; read data is set up in the address phase
  // so it stands from a flop in the data phase.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h0000_0000;
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend     <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      wr_addr     <= {haddr_i[7:2], 2'h0};
      hrdata_o    <= 32'h0000_0000;
      if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
        case ({haddr_i[7:2], 2'h0})
          PORT_E_ASSIGN_OFS: begin
            hrdata_o[FREE_CYCLE_EN_BIT] <= free_cycle_en;
            hrdata_o[RW_PIN_EN_BIT]     <= rw_pin_en;
            hrdata_o[LOW_STROBE_EN_BIT] <= low_strobe_enable;
            hrdata_o[BUS_CLOCK_OUT_DISABLE_BIT]  <= bus_clock_out_disable;
          end
          EXT_BUS_CTRL_OFS: begin
            hrdata_o[STRETCH_EN_BIT]        <= bus_clock_stretch_enable;
            hrdata_o[STRETCH_LSB +: 2]      <= stretch_amount;
            hrdata_o[INT_VIS_BIT]           <= internal_visibility;
            hrdata_o[TAG_EN_BIT]            <= tag_en;
          end
          PULLUP_CTRL_OFS: begin
            hrdata_o[PE_PULLUP_EN_BIT] <= port_e_pullup_enable;
          end
          PORT_S_PULL_OFS: begin
            hrdata_o[15:0] <= {port_s_pull_polarity, port_s_pull_enable};
          end
          AUX_PULL_OFS: begin
            hrdata_o[4:0] <= aux_pull_en;
          end
          STATUS_OFS: begin
            hrdata_o[2:0]           <= strap.mode;
            hrdata_o[ST_OSC_BIT]    <= strap.osc_sel;
            hrdata_o[ST_RUN_BIT]    <= core_run_o;
            hrdata_o[ST_INTRST_BIT] <= int_reset;
          end
          default: begin
            hrdata_o <= 32'h0000_0000;   // Unmapped reads return zero.
          end
        endcase
      end
    end
  end

  // Checks on the reset sequence, straps and pin functions.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  a_fail_drives_pin: assert property ((state == ST_RUN) && fail |=> reset_pin_oe_o && state == ST_DRIVE)
    else $error("failure did not drive the reset pin");
  a_strap_capture: assert property (capture |=> strap == $past(strap_s2))
    else $error("straps not captured at reset release");
  a_strap_held: assert property ((state == ST_RUN) && $past(state == ST_RUN) |-> $stable(strap))
    else $error("straps changed while running");
  a_pulldown_off: assert property ((state == ST_RUN && rpin_sync[1]) [*2] |-> !strap_pulldown_o)
    else $error("strap pull-down active out of reset");
  a_bus_clock_out_half: assert property (!bus_clock_out_hold [*2] |-> bus_clock_out_o.o != $past(bus_clock_out_o.o))
    else $error("bus clock not at half rate");
  a_bus_clock_out_stop: assert property (stop_mode_i [*3] |-> $stable(bus_clock_out_o.o))
    else $error("bus clock toggled in stop mode");
  a_single_chip_in: assert property ((strap.mode == MODE_NORMAL_SINGLE) [*2] |-> !bus_clock_out_o.oe)
    else $error("clock pin driven in normal single chip");
  a_strobe_gate: assert property (!low_strobe_enable |=> !low_strobe_oe_o)
    else $error("low strobe enabled without its bit");
  a_tag_cause: assert property (tag_high_half_o |-> $past(bus_clock_out) && !$past(dbg_sync[1]) && $past(tag_en))
    else $error("tag without a low debug pin at falling clock");
  a_narrow_nostr: assert property ((strap.mode == MODE_NORMAL_NARROW) |-> stretch_cnt == 2'h0)
    else $error("clock stretched in normal narrow mode");

  c_int_reset: cover property (state == ST_RUN && watchdog_monitor_fail_i ##1 state == ST_DRIVE);
  c_stretch: cover property (bus_clock_out && stretch_cnt == 2'h3);
  c_tag: cover property (tag_high_half_o);
  c_release: cover property ($rose(core_run_o));

endmodule // rspf_top

`default_nettype wire

// ---- testbench/rspf_board.sv ----
// Board model: reset pin pull-up and button, strap resistors, tag line.
// Assumes the bench clock and the block's open-drain reset pin enable.
`timescale 1ns/1ps
`default_nettype none
module rspf_board (
  input  wire logic       clock_i,
  input  wire logic       pin_oe_i,
  input  wire logic       button_i,
  input  wire logic [3:0] strap_i,
  input  wire logic       tag_req_i,
  output logic            reset_pin_o,
  output logic [3:0]      strap_o,
  output logic            debug_pin_o
);
  // Open drain with pull-up: low while either party pulls it.
  assign reset_pin_o = !(pin_oe_i || button_i);
  // Strap resistors fix the levels seen at reset release.
  assign strap_o = strap_i;
  // The debugger changes its tag line only at the falling clock edge.
  always @(negedge clock_i) debug_pin_o <= !tag_req_i;
endmodule // rspf_board
`default_nettype wire

// ---- testbench/rspf_top_bench.sv ----
// Bench for the reset, strap and pin-function block.
// Assumes the board model beside it and a 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module rspf_top_bench;
  import rspf_pkg::*;
  logic        clock_i = 1'b0, rst_b_i = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        wdog = 1'b0, stop = 1'b0, busy = 1'b1, ext = 1'b0, tag = 1'b0;
  logic        cmon = 1'b0, btn = 1'b0; // Clock monitor failure and board reset button.
  logic        hrdy, hrsp, pin, pin_oe, pin_o, run, pdn, thh, fci, dbg;
  logic        bpu, rwoe, lsoe, pepu, absel;
  logic [7:0]  haddr = 8'h00, ps_up, ps_dn;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [4:0]  aux;
  logic [3:0]  strap = 4'h9, spin; // Strap levels as {mode, osc}.
  rspf_pin_t   bclk;
  int          n_fail = 0, checked = 0, cyc = 0;
  rspf_top dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hrdata_o(hrdata), .hresp_o(hrsp), .reset_pin_i(pin),
    .reset_pin_o(pin_o), .reset_pin_oe_o(pin_oe), .watchdog_monitor_fail_i(wdog),
    .clock_monitor_fail_i(cmon), .core_run_o(run), .mode_strap_c_i(spin[3]),
    .mode_strap_b_i(spin[2]), .mode_strap_a_i(spin[1]), .osc_select_strap_i(spin[0]),
    .debug_pin_i(dbg), .strap_pulldown_o(pdn), .tag_high_half_o(thh), .stop_mode_i(stop),
    .cpu_bus_busy_i(busy), .ext_access_i(ext), .free_cycle_indicator_o(fci),
    .bus_clock_out_o(bclk), .bus_clock_pullup_o(bpu), .rw_pin_oe_o(rwoe),
    .low_strobe_oe_o(lsoe), .pe32_pullup_o(pepu), .port_ab_bus_sel_o(absel),
    .port_s_pullup_o(ps_up), .port_s_pulldown_o(ps_dn), .aux_pull_enable_o(aux));
  rspf_board board_u (.clock_i(clock_i), .pin_oe_i(pin_oe), .button_i(btn), .strap_i(strap),
    .tag_req_i(tag), .reset_pin_o(pin), .strap_o(spin), .debug_pin_o(dbg));
  // Free-running clock, 8 ns period.
  initial forever #4 clock_i = ~clock_i;
  // A hang is cut short well above the several hundred cycles the tests need.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One AHB-Lite single transfer; entered just after a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    @(posedge clock_i);
    while (hrdy !== 1'b1) @(posedge clock_i);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge clock_i);
    while (hrdy !== 1'b1) @(posedge clock_i);
    rd = hrdata;
  endtask
  task automatic wait_run();
    for (int i = 0; i < 300 && run !== 1'b1; i++) @(posedge clock_i);
    chk("core_run", 1, run);
  endtask
  // Full reset with given straps, then capture and hold of the straps.
  task automatic t_reset(input logic [3:0] s);
    strap <= s; rst_b_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    chk("pin_oe", 1, pin_oe);
    chk("pulldown", 1, pdn);
    chk("ps_up", 8'hFF, ps_up);
    chk("aux", 0, aux);
    rst_b_i <= 1'b1;
    wait_run();
    chk("pulldown", 0, pdn);
    bus(0, STATUS_OFS, 0);
    chk("status", {1'b1, s[0], s[3:1]}, rd[4:0]);
    strap <= ~s;
    repeat (4) @(posedge clock_i);
    bus(0, STATUS_OFS, 0);
    chk("held", {1'b1, s[0], s[3:1]}, rd[4:0]);
    strap <= s;
    $display("test reset %h done", s);
  endtask
  task automatic t_single();
    chk("bclk oe", 0, bclk.oe);
    chk("bclk pu", 1, bpu);
    bus(1, PULLUP_CTRL_OFS, 0);
    bus(1, PORT_S_PULL_OFS, 32'h0000_01FF);
    repeat (2) @(posedge clock_i);
    chk("bclk pu", 0, bpu);
    chk("ps_dn", 8'h01, ps_dn);
    chk("ps_up", 8'hFE, ps_up);
    $display("test single chip done");
  endtask
  task automatic t_narrow();
    logic b0;
    chk("bclk oe", 1, bclk.oe);
    chk("ab sel", 1, absel);
    chk("ls oe", 0, lsoe);
    ext <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      b0 = bclk.o;
      @(posedge clock_i);
      chk("toggle", !b0, bclk.o);
    end
    stop <= 1'b1;
    repeat (3) @(posedge clock_i);
    b0 = bclk.o;
    repeat (3) @(posedge clock_i);
    chk("stopped", b0, bclk.o);
    stop <= 1'b0; ext <= 1'b0;
    bus(1, PORT_E_ASSIGN_OFS, 32'h9);
    bus(1, EXT_BUS_CTRL_OFS, 32'h10);
    busy <= 1'b0; tag <= 1'b1;
    b0 = 1'b0;
    for (int i = 0; i < 12; i++) @(posedge clock_i) b0 = b0 | thh;
    chk("tag", 1, b0);
    chk("free cycle", 1, fci);
    chk("ls oe", 1, lsoe);
    busy <= 1'b1; tag <= 1'b0;
    bus(1, PORT_E_ASSIGN_OFS, 32'h10);
    repeat (2) @(posedge clock_i);
    chk("free cycle", 0, fci);
    chk("bclk oe", 0, bclk.oe);
    bus(1, EXT_BUS_CTRL_OFS, 32'h8);
    repeat (2) @(posedge clock_i);
    chk("bclk oe", 1, bclk.oe);
    bus(0, 8'h40, 0);
    chk("unmapped", 0, rd);
    chk("hresp", 0, hrsp);
    $display("test narrow done");
  endtask
  // Internal failure from either monitor, then a reset from the board pin.
  task automatic t_fail(input logic cm);
    if (cm) cmon <= 1'b1;
    else wdog <= 1'b1;
    @(posedge clock_i);
    wdog <= 1'b0; cmon <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk("fail oe", 1, pin_oe);
    chk("pin level", 0, pin_o);
    chk("fail run", 0, run);
    wait_run();
    bus(0, STATUS_OFS, 0);
    chk("internal", 1, rd[ST_INTRST_BIT]);
    btn <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk("btn oe", 1, pin_oe);
    chk("btn run", 0, run);
    btn <= 1'b0;
    wait_run();
    bus(0, STATUS_OFS, 0);
    chk("external", 0, rd[ST_INTRST_BIT]);
    $display("test failure reset done");
  endtask
  task automatic t_test();
    int n;
    chk("rw oe", 1, rwoe);
    chk("ls oe", 1, lsoe);
    chk("pe32 pu", 0, pepu);
    ext <= 1'b1;
    // Let a high phase begun before the request pass, then time a fresh one.
    @(posedge clock_i);
    for (int i = 0; i < 8 && bclk.o !== 1'b0; i++) @(posedge clock_i);
    for (int i = 0; i < 8 && bclk.o !== 1'b1; i++) @(posedge clock_i);
    for (n = 0; n < 10 && bclk.o === 1'b1; n++) @(posedge clock_i);
    chk("stretched", STRETCH_RST + 32'd1, n);
    ext <= 1'b0;
    $display("test special mode done");
  endtask
  initial begin
    t_reset(4'h9);
    t_single();
    t_reset(4'hA);
    t_narrow();
    t_fail(1'b0);
    t_fail(1'b1);
    t_reset(4'h5);
    t_test();
    complete_run();
  end
endmodule // rspf_top_bench
`default_nettype wire
